/* design/mcu_decoder_defs.vh */
// Purpose: Constants shared by the instruction decoder and its field splitter.
// Assumes: 14-bit instruction words, four oscillator periods per instruction cycle.
// Notes: Phase and op codes are internal encodings.
`ifndef MCU_DECODER_DEFS_VH
`define MCU_DECODER_DEFS_VH
`define INSN_W 14
`define FADDR_W 7
`define LIT_W 8
`define JMP_W 11
`define PC_W 13
`define PHASES_PER_CYCLE 4
`define PH_LAST 2'h3
`define GRP_BYTE 2'h0
`define GRP_BIT 2'h1
`define GRP_BRANCH 2'h2
`define GRP_LIT 2'h3
`define BYTE_SKIP_DEC 4'hB
`define BYTE_SKIP_INC 4'hF
`define BIT_CLR 2'h0
`define BIT_SET 2'h1
`define BIT_TSTC 2'h2
`define BIT_TSTS 2'h3
`define WORD_SLEEP 14'h0063
`define WORD_CLRWDT 14'h0064
`define WORD_RETURN 14'h0008
`define WORD_RETFIE 14'h0009
`define LIT_RETLW 4'hD
`define NOP_WORD 14'h0000
`define PC_RESET 13'h0000
`endif

/* design/insn_fields.v */
// Purpose: Splits one instruction word into its group and operand fields.
// Assumes: Purely combinational; word is stable for the decode cycle.
// Notes: Don't-care bits are never examined.
`include "mcu_decoder_defs.vh"
module insn_fields (
   input wire [`INSN_W-1:0] insnWord,
   output wire [1:0] opGroup,
   output wire [3:0] byteOp,
   output wire destSel,
   output wire [`FADDR_W-1:0] fileAddr,
   output wire [1:0] bitOp,
   output wire [2:0] bitNum,
   output wire [`LIT_W-1:0] litVal,
   output wire [`JMP_W-1:0] jumpTarget,
   output wire isCall
);
   assign opGroup = insnWord[13:12]; // [RULE_02]
   assign byteOp = insnWord[11:8]; // [RULE_11]
   assign destSel = insnWord[7]; // [RULE_11]
   assign fileAddr = insnWord[6:0]; // [RULE_04]
   assign bitOp = insnWord[11:10]; // [RULE_12]
   assign bitNum = insnWord[9:7]; // [RULE_12]
   assign litVal = insnWord[7:0]; // [RULE_06]
   assign jumpTarget = insnWord[10:0]; // [RULE_06]
   assign isCall = ~insnWord[11];
endmodule // insn_fields

/* design/mcu_instruction_decoder.v */
// Purpose: Decodes fetched instruction words and sequences their execution cycles.
// Assumes: Program memory returns progData for progAddr within two core clocks, half an instruction cycle.
// Notes: The datapath supplies the tested bit and skip-on-zero result.
//
// What this block does
// [RULE_01] Each instruction is one 14-bit word split into op code and operand fields.
// [RULE_02] Every word is classed as byte, bit, or literal and control operation.
// [RULE_03] Byte operations write the accumulator when d is 0, the file when 1.
// [RULE_04] The seven-bit file address selects one register from 0x00 to 0x7F.
// [RULE_05] Bit operations clear, set or test the numbered bit of the file.
// [RULE_06] Literal operations yield eight-bit constants; branches yield eleven-bit targets.
// [RULE_07] Don't-care encoding bits are ignored; either value decodes the same.
// [RULE_08] One cycle per instruction; true tests or branches add a no-operation cycle.
// [RULE_09] Each instruction cycle spans exactly four oscillator periods.
// [RULE_10] The next word is prefetched and discarded when a branch or skip occurs.
// [RULE_11] Byte encodings: 00, four-bit op, destination bit, seven-bit address.
// [RULE_12] Bit encodings: 01, two-bit selector, three-bit bit number, address.
// [RULE_13] The standby word 0x0063 runs in one cycle and updates timeout and powerdown flags.
`include "mcu_decoder_defs.vh"
module mcu_instruction_decoder (
   input wire core_clk,
   input wire srst,
   input wire [`INSN_W-1:0] progData,
   input wire testBitValue,
   input wire resultZero,
   output reg [`PC_W-1:0] progAddr,
   output reg cycleStrobe,
   output reg [1:0] opGroup_r,
   output reg [3:0] byteOp_r,
   output reg [`FADDR_W-1:0] fileAddr_r,
   output reg [1:0] bitOp_r,
   output reg [2:0] bitNum_r,
   output reg [7:0] bitMask_r,
   output reg [`LIT_W-1:0] litVal_r,
   output reg writeAccum_r,
   output reg writeFile_r,
   output reg flushCycle_r,
   output reg timeout_flag,
   output reg powerdown_flag
);
   reg [1:0] phase_r;
   reg [`INSN_W-1:0] execWord_r;
   reg [`INSN_W-1:0] fetchWord_r;
   reg [`PC_W-1:0] pcNext_r;
   reg [`PC_W-1:0] stackTop_r;
   reg flush_r;
   reg [`PC_W-1:0] pcAfter;
   reg takeExtra;
   reg writeAccum_nxt;
   reg writeFile_nxt;
   wire [1:0] opGroup;
   wire [3:0] byteOp;
   wire destSel;
   wire [`FADDR_W-1:0] fileAddr;
   wire [1:0] bitOp;
   wire [2:0] bitNum;
   wire [`LIT_W-1:0] litVal;
   wire [`JMP_W-1:0] jumpTarget;
   wire isCall;
   wire cycleEnd;

   function [7:0] bit_mask;
      input [2:0] num;
      begin
         bit_mask = 8'h01 << num;
      end
   endfunction

   insn_fields u_fields (
      .insnWord(execWord_r),
      .opGroup(opGroup),
      .byteOp(byteOp),
      .destSel(destSel),
      .fileAddr(fileAddr),
      .bitOp(bitOp),
      .bitNum(bitNum),
      .litVal(litVal),
      .jumpTarget(jumpTarget),
      .isCall(isCall)
   ); // [RULE_01]

   // Four core clocks stand in for the four oscillator periods of one cycle.
   assign cycleEnd = (phase_r == `PH_LAST); // [RULE_09]

   always @* begin
      pcAfter = pcNext_r;
      takeExtra = 1'b0;
      writeAccum_nxt = 1'b0;
      writeFile_nxt = 1'b0;
      case (opGroup)
         `GRP_BYTE: begin
            writeAccum_nxt = ~destSel; // [RULE_03]
            writeFile_nxt = destSel; // [RULE_03]
            if (execWord_r[13:8] == 6'h00 && !destSel) begin
               // Control words share the zero op code and write nothing.
               writeAccum_nxt = 1'b0;
               if (execWord_r == `WORD_RETURN || execWord_r == `WORD_RETFIE) begin
                  pcAfter = stackTop_r;
                  takeExtra = 1'b1; // [RULE_08]
               end
            end
            if ((byteOp == `BYTE_SKIP_DEC || byteOp == `BYTE_SKIP_INC) && resultZero) begin
               takeExtra = 1'b1; // [RULE_08]
            end
         end
         `GRP_BIT: begin
            writeFile_nxt = (bitOp == `BIT_CLR) || (bitOp == `BIT_SET); // [RULE_05]
            if ((bitOp == `BIT_TSTC && !testBitValue) ||
                (bitOp == `BIT_TSTS && testBitValue)) begin
               takeExtra = 1'b1; // [RULE_08]
            end
         end
         `GRP_BRANCH: begin
            pcAfter = {2'h0, jumpTarget};
            takeExtra = 1'b1; // [RULE_08]
         end
         `GRP_LIT: begin
            writeAccum_nxt = 1'b1;
            // Only the top two op bits matter here, so don't-care bits never reach decode.
            if (execWord_r[11:10] == 2'h1) begin // [RULE_07]
               pcAfter = stackTop_r;
               takeExtra = 1'b1; // [RULE_08]
            end
         end
         default: begin
            takeExtra = 1'b0;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (srst) begin
         phase_r <= 2'h0;
         progAddr <= `PC_RESET;
         // The successor address always runs one word ahead of the fetch address.
         pcNext_r <= `PC_RESET + 13'h0001;
         stackTop_r <= `PC_RESET;
         execWord_r <= `NOP_WORD;
         fetchWord_r <= `NOP_WORD;
         flush_r <= 1'b1;
         cycleStrobe <= 1'b0;
      end else begin
         phase_r <= phase_r + 2'h1; // [RULE_09]
         cycleStrobe <= cycleEnd;
         if (phase_r == 2'h1) begin
            fetchWord_r <= progData; // [RULE_10]
         end
         if (cycleEnd) begin
            if (flush_r) begin
               // The forced no-operation cycle executes nothing and takes the new word.
               execWord_r <= fetchWord_r;
               flush_r <= 1'b0;
               progAddr <= pcNext_r;
               pcNext_r <= pcNext_r + 13'h0001;
            end else begin
               if (opGroup == `GRP_BRANCH && isCall) begin
                  // The word after the call is the one being fetched right now.
                  stackTop_r <= progAddr;
               end
               // A skip lands on pcNext_r, two words past the executing one.
               if (takeExtra) begin
                  // The prefetched word is dropped; a no-op word fills the slot.
                  execWord_r <= `NOP_WORD; // [RULE_10]
                  flush_r <= 1'b1; // [RULE_08]
                  progAddr <= pcAfter;
                  pcNext_r <= pcAfter + 13'h0001;
               end else begin
                  execWord_r <= fetchWord_r; // [RULE_10]
                  progAddr <= pcNext_r;
                  pcNext_r <= pcNext_r + 13'h0001;
               end
            end
         end
      end
   end

   // Decoded fields stand for a whole cycle so the datapath always sees them settled.
   always @(posedge core_clk) begin
      if (srst) begin
         opGroup_r <= 2'h0;
         byteOp_r <= 4'h0;
         fileAddr_r <= {`FADDR_W{1'b0}};
         bitOp_r <= 2'h0;
         bitNum_r <= 3'h0;
         bitMask_r <= 8'h00;
         litVal_r <= {`LIT_W{1'b0}};
         writeAccum_r <= 1'b0;
         writeFile_r <= 1'b0;
         flushCycle_r <= 1'b0;
      end else if (cycleEnd) begin
         opGroup_r <= opGroup; // [RULE_02]
         byteOp_r <= byteOp;
         fileAddr_r <= fileAddr; // [RULE_04]
         bitOp_r <= bitOp;
         bitNum_r <= bitNum;
         bitMask_r <= bit_mask(bitNum); // [RULE_05]
         litVal_r <= litVal; // [RULE_06]
         flushCycle_r <= flush_r;
         writeAccum_r <= writeAccum_nxt & ~flush_r;
         writeFile_r <= writeFile_nxt & ~flush_r;
      end
   end

   // The status flags move only when a standby or watchdog-clear word really executes.
   // Both read 1 after reset, just as after a power-up.
   always @(posedge core_clk) begin
      if (srst) begin
         timeout_flag <= 1'b1;
         powerdown_flag <= 1'b1;
      end else if (cycleEnd && !flush_r) begin
         if (execWord_r == `WORD_SLEEP) begin
            timeout_flag <= 1'b1; // [RULE_13]
            powerdown_flag <= 1'b0; // [RULE_13]
         end
         if (execWord_r == `WORD_CLRWDT) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
         end
      end
   end
endmodule // mcu_instruction_decoder

/* testbench/decoder_monitor.sv */
// Purpose: Assertions on the decoder outputs.
// Assumes: Bound into mcu_instruction_decoder.
// Notes: Test and flush cycles must never write.
`include "mcu_decoder_defs.vh"
module decoder_monitor (
   input wire core_clk,
   input wire srst,
   input wire cycleStrobe,
   input wire [1:0] opGroup_r,
   input wire [1:0] bitOp_r,
   input wire [2:0] bitNum_r,
   input wire [7:0] bitMask_r,
   input wire writeAccum_r,
   input wire writeFile_r,
   input wire flushCycle_r,
   input wire timeout_flag,
   input wire powerdown_flag
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   wire live = cycleStrobe && !flushCycle_r;
   a_cycle_four: assert property (cycleStrobe |=> (!cycleStrobe)[*3] ##1 cycleStrobe)
      else $error("strobe spacing");
   a_fields_stand: assert property (cycleStrobe |=> $stable(opGroup_r)[*2])
      else $error("fields moved");
   a_flush_quiet: assert property (flushCycle_r |-> !writeAccum_r && !writeFile_r)
      else $error("flush wrote");
   a_one_dest: assert property (!(writeAccum_r && writeFile_r))
      else $error("two targets");
   a_mask_match: assert property (live && opGroup_r == `GRP_BIT |->
      bitMask_r == (8'h01 << bitNum_r)) else $error("bad mask");
   a_test_nowrite: assert property (opGroup_r == `GRP_BIT && bitOp_r[1] |->
      !writeFile_r && !writeAccum_r) else $error("test wrote");
   a_bit_write: assert property (live && opGroup_r == `GRP_BIT && !bitOp_r[1] |->
      writeFile_r) else $error("bit no write");
   a_lit_accum: assert property (live && opGroup_r == `GRP_LIT |-> writeAccum_r)
      else $error("literal no write");
   a_reset_flags: assert property ($fell(srst) |-> timeout_flag && powerdown_flag)
      else $error("flags after reset");
   c_flush: cover property (flushCycle_r);
   c_test: cover property (live && opGroup_r == `GRP_BIT && bitOp_r[1]);
   c_sleep: cover property (cycleStrobe && !powerdown_flag);
endmodule // decoder_monitor
bind mcu_instruction_decoder decoder_monitor u_mon (.*);

/* testbench/prog_memory.sv */
// Purpose: Program memory model feeding instruction words.
// Assumes: Read is asynchronous; the bench loads the array.
// Notes: Only 2K words exist, so upper address bits are ignored.
module prog_memory (
   input wire [12:0] progAddr,
   output logic [13:0] progData
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [13:0] mem [0:2047];
   assign progData = mem[progAddr[10:0]];
endmodule // prog_memory

/* testbench/testbench.sv */
// Purpose: Random program run through the decoder against a bench model.
// Assumes: Test inputs driven after one strobe serve the word shown at the next strobe.
// Notes: Flags are expected to change at the strobe that shows the special word.
`include "mcu_decoder_defs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, srst, testBitValue, resultZero, cycleStrobe, writeAccum_r, writeFile_r;
   logic flushCycle_r, timeout_flag, powerdown_flag, fl, sp, sk;
   logic [12:0] progAddr;
   logic [13:0] progData, w;
   logic [1:0] opGroup_r, bitOp_r, fx;
   logic [3:0] byteOp_r;
   logic [6:0] fileAddr_r;
   logic [2:0] bitNum_r;
   logic [7:0] bitMask_r, litVal_r;
   logic [31:0] rnd;
   int n_errors, samples_checked, cycles, pc;
   mcu_instruction_decoder u_dut (.*);
   prog_memory u_mem (.*);
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [13:0] gen(input logic [31:0] r);
      logic [3:0] k;
      k = r[23:20];
      // Return with literal would need a stack model, so it is steered away.
      if (k[3:2] == 2'h1) k[3] = 1'b1;
      case (r[3:2])
         2'h0: return {2'h0, (r[7:4] == 4'h0) ? 4'h7 : r[7:4], r[8], r[15:9]};
         2'h1: return {2'h1, r[17:16], r[20:18], r[15:9]};
         2'h2: return {2'h3, k, r[31:24]};
         default: return (r[27:25] == 3'h0) ? (r[24] ? `WORD_SLEEP : `WORD_CLRWDT) :
            {2'h2, r[12], r[10:0]};
      endcase
   endfunction
   task automatic chk(input logic [12:0] s, input logic [12:0] e, input string m);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", m, e, s);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 4000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic run(input int n);
      pc = 0;
      fl = 1'b1;
      fx = 2'h3;
      repeat (n) begin
         for (int t = 0; t < 8 && cycleStrobe !== 1'b1; t++) @(posedge core_clk) #2;
         chk(cycleStrobe, 1'b1, "strobe");
         w = u_mem.mem[pc];
         sp = !fl && (w == `WORD_SLEEP || w == `WORD_CLRWDT);
         if (sp) fx = w[0] ? 2'h2 : 2'h3;
         chk(flushCycle_r, fl, "flush");
         chk({timeout_flag, powerdown_flag}, fx, "flags");
         if (fl) chk({writeAccum_r, writeFile_r}, 0, "flushwr");
         else begin
            chk(opGroup_r, w[13:12], "group");
            if (!w[13]) chk(fileAddr_r, w[6:0], "faddr");
            if (w[13:12] == 2'h0) begin
               chk(byteOp_r, w[11:8], "op");
               chk({writeAccum_r, writeFile_r}, sp ? 2'h0 : {!w[7], w[7]}, "dest");
            end
            if (w[13:12] == 2'h1) begin
               chk({bitOp_r, bitNum_r}, w[11:7], "bitf");
               chk(bitMask_r, 8'h01 << w[9:7], "mask");
               chk({writeAccum_r, writeFile_r}, {1'b0, !w[11]}, "bitwr");
            end
            if (w[13:12] == 2'h3) chk({writeAccum_r, litVal_r}, {1'b1, w[7:0]}, "lit");
         end
         // The pins still carry what the design sampled when it decided this word.
         sk = !fl && (w[13:12] == 2'h1 && w[11] && w[10] == testBitValue ||
            w[13:12] == 2'h0 && w[11] && w[9:8] == 2'h3 && resultZero);
         if (!fl && w[13:12] == 2'h2) pc = w[10:0];
         else if (!fl) pc = (pc + 1 + sk) % 2048;
         fl = !fl && (sk || w[13:12] == 2'h2);
         chk(progAddr[10:0], (pc + !fl) % 2048, "addr");
         rnd = lfsr(rnd);
         testBitValue = rnd[0];
         resultZero = rnd[1];
         @(posedge core_clk) #2;
      end
   endtask
   initial begin
      srst = 1'b1;
      testBitValue = 1'b0;
      resultZero = 1'b0;
      rnd = 32'h80469AF7;
      for (int i = 0; i < 2048; i++) begin
         rnd = lfsr(rnd);
         u_mem.mem[i] = gen(rnd);
      end
      u_mem.mem[0] = `WORD_SLEEP;
      u_mem.mem[1] = 14'h1FFF;
      u_mem.mem[2] = 14'h1FFF;
      u_mem.mem[3] = 14'h2FFF;
      u_mem.mem[2047] = 14'h0FFF;
      repeat (6) @(posedge core_clk);
      #2 srst = 1'b0;
      run(250);
      srst = 1'b1;
      repeat (6) @(posedge core_clk);
      #2 srst = 1'b0;
      run(250);
      stop_test();
   end
endmodule // testbench
